// [pkg/tepl_regs.svh]
`ifndef TEPL_REGS_SVH
`define TEPL_REGS_SVH
// ------------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------------
`define TEPL_OFS_CTRL 12'h000
`define TEPL_OFS_T0 12'h004
`define TEPL_OFS_T1 12'h008
`define TEPL_OFS_T2 12'h00c
`define TEPL_OFS_RELOAD 12'h010
`define TEPL_OFS_CAPTURE 12'h014
`define TEPL_OFS_STATUS 12'h018
// ------------------------------------------------------------------
// control fields
// ------------------------------------------------------------------
`define TEPL_CTRL_T0_CNT 0
`define TEPL_CTRL_T1_CNT 1
`define TEPL_CTRL_T0_RUN 2
`define TEPL_CTRL_T1_RUN 3
`define TEPL_CTRL_T2_RUN 4
`define TEPL_CTRL_T2_EXTCLK 5
`define TEPL_CTRL_MODE_LO 8
`define TEPL_CTRL_MODE_HI 9
`define TEPL_CTRL_RESET 32'h0000_0000
`define TEPL_STAT_CAPT 0
`define TEPL_STAT_DIR 1
`define TEPL_STAT_PINS_LO 4
`endif

// [pkg/tepl_pkg.sv]
package tepl_pkg;
  // timer 2 operating mode
  typedef enum logic [1:0] {
    TEPL_T2_RELOAD = 2'h0,
    TEPL_T2_CAPTURE = 2'h1,
    TEPL_T2_UPDOWN = 2'h2,
    TEPL_T2_CLKOUT = 2'h3
  } tepl_t2_mode_t;
  // ahb address phase captured for the data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } tepl_aphase_t;
endpackage

// [verilog/tepl_timer_pins.sv]
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tepl_regs.svh"
module tepl_timer_pins #(
  parameter int WIDTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] timer01_count_pins,
  input wire logic timer2_clock_pin_i,
  output logic timer2_clock_pin_o,
  output logic timer2_clock_pin_oe_n,
  input wire logic timer2_external_input
);
  // ------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic [3:0] pins_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  logic [3:0] fall;
  assign pins_raw = {timer2_external_input, timer2_clock_pin_i,
                     timer01_count_pins};
  // two flops before any logic, third flop holds last sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
      prev_q <= 4'hf;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  // high-to-low between consecutive synchronised samples
  assign fall = prev_q & ~sync2_q;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [WIDTH-1:0] t0_q;
  logic [WIDTH-1:0] t1_q;
  logic [WIDTH-1:0] t2_q;
  logic [WIDTH-1:0] reload_q;
  logic [WIDTH-1:0] capture_q;
  logic capt_flag_q;
  logic clkout_q;
  tepl_pkg::tepl_aphase_t aph_q;
  tepl_pkg::tepl_t2_mode_t mode;
  logic t2_tick;
  logic wr_en;
  logic capt_clr;
  assign mode = tepl_pkg::tepl_t2_mode_t'(
    ctrl_q[`TEPL_CTRL_MODE_HI:`TEPL_CTRL_MODE_LO]);
  assign wr_en = aph_q.valid && aph_q.write;
  assign capt_clr = wr_en && aph_q.addr == `TEPL_OFS_STATUS &&
                    hwdata[`TEPL_STAT_CAPT];

  // single-cycle slave: always ready, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
    end else if (hready) begin
      aph_q.valid <= hsel && htrans[1];
      aph_q.write <= hwrite;
      aph_q.addr <= {haddr[11:2], 2'h0};
    end
  end

  // control register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `TEPL_CTRL_RESET;
    end else if (wr_en && aph_q.addr == `TEPL_OFS_CTRL) begin
      ctrl_q <= {22'h0, hwdata[9:0]};
    end
  end

  // reload value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_q <= '0;
    end else if (wr_en && aph_q.addr == `TEPL_OFS_RELOAD) begin
      reload_q <= hwdata[WIDTH-1:0];
    end
  end

  // ------------------------------------------------------------------
  // timers 0 and 1
  // ------------------------------------------------------------------
  // counter mode counts pin falls, else one count per core clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t0_q <= '0;
    end else if (wr_en && aph_q.addr == `TEPL_OFS_T0) begin
      t0_q <= hwdata[WIDTH-1:0];
    end else if (ctrl_q[`TEPL_CTRL_T0_RUN] &&
                 (!ctrl_q[`TEPL_CTRL_T0_CNT] || fall[0])) begin
      t0_q <= t0_q + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_q <= '0;
    end else if (wr_en && aph_q.addr == `TEPL_OFS_T1) begin
      t1_q <= hwdata[WIDTH-1:0];
    end else if (ctrl_q[`TEPL_CTRL_T1_RUN] &&
                 (!ctrl_q[`TEPL_CTRL_T1_CNT] || fall[1])) begin
      t1_q <= t1_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // timer 2
  // ------------------------------------------------------------------
  // external clock only honoured in capture mode, pin is input there
  assign t2_tick = ctrl_q[`TEPL_CTRL_T2_RUN] &&
    ((mode == tepl_pkg::TEPL_T2_CAPTURE && ctrl_q[`TEPL_CTRL_T2_EXTCLK])
     ? fall[2] : 1'b1);

  // reload on pin fall wins over counting; software write wins over all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t2_q <= '0;
    end else if (wr_en && aph_q.addr == `TEPL_OFS_T2) begin
      t2_q <= hwdata[WIDTH-1:0];
    end else begin
      case (mode)
        tepl_pkg::TEPL_T2_RELOAD: begin
          if (fall[3]) begin
            t2_q <= reload_q;
          end else if (t2_tick) begin
            t2_q <= (&t2_q) ? reload_q : t2_q + 1'b1;
          end
        end
        tepl_pkg::TEPL_T2_UPDOWN: begin
          if (t2_tick) begin
            // level sampled after synchroniser; source holds it
            t2_q <= sync2_q[3] ? t2_q + 1'b1 : t2_q - 1'b1;
          end
        end
        tepl_pkg::TEPL_T2_CLKOUT: begin
          // overflow reloads and toggles the output clock
          if (t2_tick) begin
            t2_q <= (&t2_q) ? reload_q : t2_q + 1'b1;
          end
        end
        tepl_pkg::TEPL_T2_CAPTURE: begin
          if (t2_tick) begin
            t2_q <= t2_q + 1'b1;
          end
        end
        default: begin
          t2_q <= t2_q;
        end
      endcase
    end
  end

  // capture on external input fall; set beats software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_q <= '0;
      capt_flag_q <= 1'b0;
    end else if (mode == tepl_pkg::TEPL_T2_CAPTURE && fall[3]) begin
      capture_q <= t2_q;
      capt_flag_q <= 1'b1;
    end else if (capt_clr) begin
      capt_flag_q <= 1'b0;
    end
  end

  // clock-out toggles on each timer 2 overflow in clock-out mode, held low in other modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clkout_q <= 1'b0;
    end else if (mode != tepl_pkg::TEPL_T2_CLKOUT) begin
      clkout_q <= 1'b0;
    end else if (t2_tick && (&t2_q)) begin
      clkout_q <= ~clkout_q;
    end
  end

  // pin driver: enable low only in clock-out mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer2_clock_pin_o <= 1'b0;
      timer2_clock_pin_oe_n <= 1'b1;
    end else begin
      timer2_clock_pin_o <= clkout_q;
      timer2_clock_pin_oe_n <= (mode != tepl_pkg::TEPL_T2_CLKOUT);
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  // registered in the address phase so data is out in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case ({haddr[11:2], 2'h0})
        `TEPL_OFS_CTRL: hrdata <= ctrl_q;
        `TEPL_OFS_T0: hrdata <= 32'(t0_q);
        `TEPL_OFS_T1: hrdata <= 32'(t1_q);
        `TEPL_OFS_T2: hrdata <= 32'(t2_q);
        `TEPL_OFS_RELOAD: hrdata <= 32'(reload_q);
        `TEPL_OFS_CAPTURE: hrdata <= 32'(capture_q);
        `TEPL_OFS_STATUS: hrdata <= {24'h0, sync2_q, 2'h0,
                                     sync2_q[3], capt_flag_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

// [tb/tepl_timer_pins_asserts.sv]
`timescale 1ns/1ps
module tepl_timer_pins_asserts #(
  parameter int WIDTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer2_clock_pin_o,
  input wire logic timer2_clock_pin_oe_n
);
  logic wr_q;
  logic rd_q;
  logic [11:0] adr_q;
  logic [1:0] md_q;
  // ----------------------------------------
  // shadow of the mode field, from bus writes
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 12'h000;
      md_q <= 2'h0;
    end else begin
      wr_q <= hready && hsel && htrans[1] && hwrite;
      rd_q <= hready && hsel && htrans[1] && !hwrite;
      if (hready) adr_q <= haddr[11:0];
      if (hready && wr_q && adr_q[11:2] == 10'h000) md_q <= hwdata[9:8];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  rdata_hold_a: assert property (!rd_q |-> $stable(hrdata))
    else $error("read data moved without a read");
  pin_input_a: assert property (md_q == 2'h1 && $past(md_q) == 2'h1
    |-> timer2_clock_pin_oe_n) else $error("clock pin driven in capture");
  pin_output_a: assert property (md_q == 2'h3 && $past(md_q) == 2'h3
    |-> !timer2_clock_pin_oe_n) else $error("clock pin not driven");
  pin_release_a: assert property (md_q != 2'h3 && $past(md_q) != 2'h3
    |-> timer2_clock_pin_oe_n) else $error("clock pin driven outside clkout");
  // clkout clears one edge after the mode, the pin one edge after that
  clk_quiet_a: assert property (md_q != 2'h3 && $past(md_q, 3) != 2'h3
    |-> $stable(timer2_clock_pin_o)) else $error("clock out moved");
  cover property (!timer2_clock_pin_oe_n && $changed(timer2_clock_pin_o));
  cover property (md_q == 2'h1 && rd_q);
  cover property (md_q == 2'h2 && wr_q);
endmodule
bind tepl_timer_pins tepl_timer_pins_asserts #(.WIDTH(WIDTH)) sva (.hclk,
  .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .timer2_clock_pin_o, .timer2_clock_pin_oe_n);

// [tb/tepl_pin_src.sv]
`timescale 1ns/1ps
// pin sources {ext input, clock pin, t1, t0}; levels held 3 cycles
// because shorter pulses may slip past the synchronisers
module tepl_pin_src (
  input wire logic hclk,
  output logic [3:0] pins
);
  initial pins = 4'hf;
  task automatic fall(input int i);
    @(posedge hclk) pins[i] <= 1'b0;
    repeat (3) @(posedge hclk);
    pins[i] <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  // direction level stays until changed
  task automatic hold(input logic v);
    @(posedge hclk) pins[3] <= v;
  endtask
endmodule

// [tb/tepl_timer_pins_bench.sv]
`timescale 1ns/1ps
`include "tepl_regs.svh"
module tepl_timer_pins_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r, q;
  logic hready, hresp, t2_o, t2_oe_n, t2_pin;
  logic [3:0] pins;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int tog, n, k;
  integer seed = 32'h86786732;
  always #50 hclk = ~hclk;
  always @(t2_o) tog++;
  // device wins the clock pin while it drives
  assign t2_pin = t2_oe_n ? pins[2] : t2_o;
  tepl_pin_src src (.hclk(hclk), .pins(pins));
  tepl_timer_pins dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .timer01_count_pins(pins[1:0]),
    .timer2_clock_pin_i(t2_pin), .timer2_clock_pin_o(t2_o),
    .timer2_clock_pin_oe_n(t2_oe_n), .timer2_external_input(pins[3]));
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `TEPL_OFS_STATUS, 0);
    chk("status", 32'hf2, r);
    bus(1, 12'h3fc, 32'hffffffff);
    bus(0, 12'h3fc, 0);
    chk("unmapped", 0, r);
    bus(1, `TEPL_OFS_CTRL, 32'hf);
    q = $random(seed) & 32'hffff;
    bus(1, `TEPL_OFS_T0, q);
    bus(1, `TEPL_OFS_T1, 32'hffff);
    n = 1 + ($random(seed) & 7);
    for (k = 0; k < n; k++) src.fall(k & 1);
    bus(0, `TEPL_OFS_T0, 0);
    chk("t0", (q + (n + 1) / 2) & 32'hffff, r);
    bus(0, `TEPL_OFS_T1, 0);
    chk("t1", (32'hffff + n / 2) & 32'hffff, r);
    bus(1, `TEPL_OFS_CTRL, 32'h130);
    bus(1, `TEPL_OFS_T2, q);
    for (k = 0; k < n; k++) src.fall(2);
    src.fall(3);
    bus(0, `TEPL_OFS_CAPTURE, 0);
    chk("capture", (q + n) & 32'hffff, r);
    bus(0, `TEPL_OFS_STATUS, 0);
    chk("capt_flag", 1, r[0]);
    bus(1, `TEPL_OFS_STATUS, 1);
    bus(0, `TEPL_OFS_STATUS, 0);
    chk("capt_clear", 0, r[0]);
    bus(1, `TEPL_OFS_CTRL, 32'h10);
    bus(1, `TEPL_OFS_RELOAD, q | 32'h8000);
    // start low so only the pin reload can reach the reload value
    bus(1, `TEPL_OFS_T2, 0);
    src.fall(3);
    bus(0, `TEPL_OFS_T2, 0);
    chk("reload", 1, r[15:0] - (q[15:0] | 16'h8000) < 16);
    bus(1, `TEPL_OFS_CTRL, 32'h210);
    for (k = 0; k < 2; k++) begin
      src.hold(k[0]);
      bus(1, `TEPL_OFS_T2, 32'h1000);
      bus(0, `TEPL_OFS_T2, 0);
      q = k ? r - 32'h1000 : 32'h1000 - r;
      chk("t2_dir", 1, q > 0 && q < 16);
      bus(0, `TEPL_OFS_STATUS, 0);
      chk("dir_flag", k, r[1]);
    end
    bus(1, `TEPL_OFS_RELOAD, 32'hfff0);
    bus(1, `TEPL_OFS_CTRL, 32'h310);
    bus(1, `TEPL_OFS_T2, 32'hfff0);
    tog = 0;
    repeat (160) @(posedge hclk);
    chk("toggles", 1, tog > 8 && tog < 12);
    chk("pin_oe_n", 0, t2_oe_n);
    report_and_stop;
  end
endmodule
